// ---- hw/pmc_core_side.sv ----
// Processor core side: takes APB orders and drives the controller's register and sleep port.
`timescale 1ns/1ps
`default_nettype none
module pmc_core_side
	import pmc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic wakeIrq,
	input wire logic wakeHigherPrio,
	input wire logic wakeHib,
	input wire logic porRst,
	pmc_if.core bus
);
	pmc_host_t st_r, st_nxt;
	logic wr_r, wr_nxt;
	logic rd_r, rd_nxt;
	logic sel_r, sel_nxt;
	logic [15:0] wdata_r, wdata_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic [3:0] coreCtl_r, coreCtl_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic access;
	logic known;

	assign access = psel & penable;
	assign known = paddr[11:0] inside {PMC_CMD_ADDR, PMC_WDATA_ADDR, PMC_STAT_ADDR, PMC_RDATA_ADDR, PMC_CORE_ADDR};

	always_comb begin
		st_nxt = st_r;
		wr_nxt = 1'b0;
		rd_nxt = 1'b0;
		sel_nxt = sel_r;
		wdata_nxt = wdata_r;
		rdata_nxt = rdata_r;
		coreCtl_nxt = coreCtl_r;
		prdata_nxt = prdata_r;
		// The read answer lands one cycle after the strobe.
		if (st_r == PMC_HBUSY) begin
			st_nxt = rd_r ? PMC_HBUSY : PMC_HIDLE;
			if (!rd_r) begin
				rdata_nxt = bus.regRdata;
			end
		end
		if (psel && !penable) begin
			prdata_nxt = 32'h0000_0000;
			case (paddr[11:0])
				PMC_WDATA_ADDR: prdata_nxt = {16'h0000, wdata_r};
				PMC_STAT_ADDR: prdata_nxt = {30'h0, bus.awake, st_r == PMC_HBUSY};
				PMC_RDATA_ADDR: prdata_nxt = {16'h0000, rdata_r};
				PMC_CORE_ADDR: prdata_nxt = {28'h000_0000, coreCtl_r};
				default: prdata_nxt = 32'h0000_0000;
			endcase
		end
		if (access && pwrite) begin
			case (paddr[11:0])
				PMC_CMD_ADDR: begin
					sel_nxt = pwdata[PMC_CMD_SEL_BIT];
					wr_nxt = pwdata[PMC_CMD_WRITE_BIT];
					rd_nxt = pwdata[PMC_CMD_READ_BIT];
					if (pwdata[PMC_CMD_READ_BIT]) begin
						st_nxt = PMC_HBUSY;
					end
				end
				PMC_WDATA_ADDR: wdata_nxt = pwdata[15:0];
				PMC_CORE_ADDR: coreCtl_nxt = pwdata[3:0];
				default: begin
				end
			endcase
		end
		// deep sleep first
		// Both are software duties; the core side passes its flags through unchecked.
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= PMC_HIDLE;
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			sel_r <= 1'b0;
			wdata_r <= 16'h0000;
			rdata_r <= 16'h0000;
			coreCtl_r <= 4'h0;
			prdata_r <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			sel_r <= sel_nxt;
			wdata_r <= wdata_nxt;
			rdata_r <= rdata_nxt;
			coreCtl_r <= coreCtl_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = access & ~known;
	assign bus.regWr = wr_r;
	assign bus.regRd = rd_r;
	assign bus.regSel = sel_r;
	assign bus.regWdata = sel_r ? wdata_r : {14'h0, wdata_r[1:0]};
	assign bus.sleepReq = coreCtl_r[PMC_CORE_SLEEP_BIT];
	assign bus.inHandler = coreCtl_r[PMC_CORE_INHANDLER_BIT];
	assign bus.deepSleep = coreCtl_r[PMC_CORE_DEEP_BIT];
	assign bus.debugHold = coreCtl_r[PMC_CORE_DEBUG_BIT];
	assign bus.wakeIrq = wakeIrq;
	assign bus.wakeHigherPrio = wakeHigherPrio;
	assign bus.wakeHib = wakeHib;
	assign bus.porRst = porRst;
endmodule : pmc_core_side
`default_nettype wire

// ---- hw/pmc_if.sv ----
// Interface joining the power mode controller to the processor core side.
`timescale 1ns/1ps
`default_nettype none
interface pmc_if;
	// Register port: strobes and write data from the core side, read data from the controller.
	logic regWr;
	logic regRd;
	logic regSel;
	logic [15:0] regWdata;
	logic [15:0] regRdata;
	// Core sleep signalling.
	logic sleepReq;
	logic deepSleep;
	logic inHandler;
	logic debugHold;
	logic wakeIrq;
	logic wakeHigherPrio;
	logic wakeHib;
	logic porRst;
	// Clock gating, power and status outputs of the controller.
	logic coreClkEn;
	logic sysClkEn;
	logic periphClkEn;
	logic freeClkEn;
	logic combPowerEn;
	logic retainEn;
	logic awake;

	modport ctrl (
		input regWr, regRd, regSel, regWdata, sleepReq, deepSleep, inHandler, debugHold,
		input wakeIrq, wakeHigherPrio, wakeHib, porRst,
		output regRdata, coreClkEn, sysClkEn, periphClkEn, freeClkEn, combPowerEn, retainEn, awake
	);
	modport core (
		output regWr, regRd, regSel, regWdata, sleepReq, deepSleep, inHandler, debugHold,
		output wakeIrq, wakeHigherPrio, wakeHib, porRst,
		input regRdata, coreClkEn, sysClkEn, periphClkEn, freeClkEn, combPowerEn, retainEn, awake
	);
endinterface : pmc_if
`default_nettype wire

// ---- hw/pmc_pkg.sv ----
// Package of constants and types shared by both ends of the power mode controller.
package pmc_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [31:0] PMC_MODE_ADDR = 32'h4000_2400;
	localparam logic [31:0] PMC_KEY_ADDR = 32'h4000_2404;
	localparam logic [15:0] PMC_MODE_RESET = 16'h0000;
	localparam logic [15:0] PMC_KEY_RESET = 16'h0000;
	localparam logic [15:0] PMC_KEY_FIRST = 16'h4859;
	localparam logic [15:0] PMC_KEY_SECOND = 16'hf27b;
	localparam int PMC_MODE_LSB = 0;
	localparam int PMC_MODE_MSB = 1;
	// ****************************************
	// Controller registers on APB
	// ****************************************
	localparam logic [11:0] PMC_CMD_ADDR = 12'h000;
	localparam logic [11:0] PMC_WDATA_ADDR = 12'h004;
	localparam logic [11:0] PMC_STAT_ADDR = 12'h008;
	localparam logic [11:0] PMC_RDATA_ADDR = 12'h00c;
	localparam logic [11:0] PMC_CORE_ADDR = 12'h010;
	localparam int PMC_CMD_WRITE_BIT = 0;
	localparam int PMC_CMD_READ_BIT = 1;
	localparam int PMC_CMD_SEL_BIT = 4;
	localparam int PMC_CORE_SLEEP_BIT = 0;
	localparam int PMC_CORE_INHANDLER_BIT = 1;
	localparam int PMC_CORE_DEEP_BIT = 2;
	localparam int PMC_CORE_DEBUG_BIT = 3;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		PMC_ACTIVE = 2'h0,
		PMC_CORE_SLEEP = 2'h1,
		PMC_SYSTEM_CLOCK_SLEEP_MODE = 2'h2,
		PMC_HIBERNATE = 2'h3
	} pmc_mode_t;
	typedef enum {PMC_LOCK, PMC_KEY1, PMC_OPEN} pmc_lock_t;
	typedef enum {PMC_RUN, PMC_LOWPOWER} pmc_state_t;
	typedef enum {PMC_HIDLE, PMC_HBUSY} pmc_host_t;
endpackage : pmc_pkg

// ---- hw/pmc_power_mode_controller.sv ----
// Always-on power mode controller: key-protected mode register and clock gating.
`timescale 1ns/1ps
`default_nettype none
module pmc_power_mode_controller
	import pmc_pkg::*;
#(
	parameter int PERIPH_COUNT = 8
)
(
	input wire logic clk,
	input wire logic sys_rst,
	pmc_if.ctrl bus,
	input wire logic [PERIPH_COUNT-1:0] periphGateOff,
	output logic [PERIPH_COUNT-1:0] periphClkEn
);
	// At least one peripheral clock gate is required; the gating loop always drives eight gates whatever the count.
	generate
		if (PERIPH_COUNT < 1) begin : gBadCount
			$error("peripheral count must be at least one");
		end
	endgenerate
	// ****************************************
	// Registers
	// ****************************************
	pmc_lock_t lock_r, lock_nxt;
	pmc_state_t state_r, state_nxt;
	logic [1:0] mode_r, mode_nxt;
	logic [15:0] key_r, key_nxt;
	logic [1:0] applied_r, applied_nxt;
	logic handlerEntry_r, handlerEntry_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic debugHold_r, debugHold_nxt;
	logic entryBlocked;
	logic wakeEvent;

	// ****************************************
	// Debug hold and wake selection
	// ****************************************
	// power-on clear
	// The hold is sticky: once debug has asked for it, sleep stays blocked until power is cycled,
	// and the system reset leaves it alone on purpose.
	always_comb begin
		debugHold_nxt = debugHold_r | bus.debugHold;
	end

	always_ff @(posedge clk or posedge bus.porRst) begin
		if (bus.porRst) begin
			debugHold_r <= 1'b0;
		end else begin
			debugHold_r <= debugHold_nxt;
		end
	end

	// debug blocks entry
	// The live request counts too, so a hold raised together with the sleep request still wins.
	assign entryBlocked = debugHold_r | bus.debugHold;

	always_comb begin
		if (handlerEntry_r) begin
			wakeEvent = bus.wakeHigherPrio;
		end else if (applied_r == PMC_HIBERNATE) begin
			wakeEvent = bus.wakeHib;
		end else begin
			wakeEvent = bus.wakeIrq | bus.wakeHigherPrio | bus.wakeHib;
		end
	end

	// ****************************************
	// Register port next values
	// ****************************************
	always_comb begin
		lock_nxt = lock_r;
		mode_nxt = mode_r;
		key_nxt = key_r;
		rdata_nxt = rdata_r;
		if (bus.regWr) begin
			if (bus.regSel) begin
				key_nxt = bus.regWdata;
				if (lock_r == PMC_LOCK && bus.regWdata == PMC_KEY_FIRST) begin
					lock_nxt = PMC_KEY1;
				end else if (lock_r == PMC_KEY1 && bus.regWdata == PMC_KEY_SECOND) begin
					lock_nxt = PMC_OPEN;
				end else begin
					lock_nxt = PMC_LOCK;
				end
			end else begin
				if (lock_r == PMC_OPEN) begin
					mode_nxt = bus.regWdata[PMC_MODE_MSB:PMC_MODE_LSB];
				end
				lock_nxt = PMC_LOCK;
			end
		end
		if (bus.regRd) begin
			rdata_nxt = bus.regSel ? key_r : {14'h0, mode_r};
		end
	end

	// ****************************************
	// Power state next values
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		applied_nxt = applied_r;
		handlerEntry_nxt = handlerEntry_r;
		case (state_r)
			PMC_RUN: begin
				if (bus.sleepReq && !entryBlocked) begin
					if (mode_r != PMC_ACTIVE && (mode_r != PMC_HIBERNATE || bus.deepSleep)) begin
						applied_nxt = mode_r;
						handlerEntry_nxt = bus.inHandler;
						state_nxt = PMC_LOWPOWER;
					end
				end
			end
			PMC_LOWPOWER: begin
				// wake to active
				// The stored mode survives, so a sleep request left standing re-enters at once.
				if (wakeEvent) begin
					applied_nxt = PMC_ACTIVE;
					handlerEntry_nxt = 1'b0;
					state_nxt = PMC_RUN;
				end
			end
			default: begin
				state_nxt = PMC_RUN;
			end
		endcase
	end

	// ****************************************
	// State registers
	// ****************************************
	// always-on state
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lock_r <= PMC_LOCK;
			mode_r <= PMC_MODE_RESET[1:0];
			key_r <= PMC_KEY_RESET;
			rdata_r <= 16'h0000;
		end else begin
			lock_r <= lock_nxt;
			mode_r <= mode_nxt;
			key_r <= key_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= PMC_RUN;
			applied_r <= PMC_ACTIVE;
			handlerEntry_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			applied_r <= applied_nxt;
			handlerEntry_r <= handlerEntry_nxt;
		end
	end

	// ****************************************
	// Clock gating outputs
	// ****************************************
	// core-only sleep
	assign bus.coreClkEn = !(bus.sleepReq || state_r == PMC_LOWPOWER);
	assign bus.sysClkEn = !(applied_r == PMC_SYSTEM_CLOCK_SLEEP_MODE || applied_r == PMC_HIBERNATE);
	assign bus.periphClkEn = bus.sysClkEn;
	assign bus.freeClkEn = applied_r != PMC_HIBERNATE;
	assign bus.combPowerEn = applied_r != PMC_HIBERNATE;
	assign bus.retainEn = applied_r == PMC_HIBERNATE;
	assign bus.awake = state_r == PMC_RUN;
	assign bus.regRdata = rdata_r;

	generate
		for (genvar i = 0; i < 8; i++) begin : gPeriph
			assign periphClkEn[i] = bus.sysClkEn & ~periphGateOff[i];
		end
	endgenerate
endmodule : pmc_power_mode_controller
`default_nettype wire

// ---- test/pmc_checker.sv ----
// Checker of the controller's clock gating and wake relations on the interface.
`timescale 1ns/1ps
`default_nettype none
module pmc_checker (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic sleepReq,
	input wire logic inHandler,
	input wire logic debugHold,
	input wire logic wakeIrq,
	input wire logic wakeHib,
	input wire logic coreClkEn,
	input wire logic sysClkEn,
	input wire logic periphClkEn,
	input wire logic freeClkEn,
	input wire logic combPowerEn,
	input wire logic retainEn,
	input wire logic awake
);
	// ****************************************
	// Gating and wake properties
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_core_gated: assert property (sleepReq |-> !coreClkEn)
		else $error("core clock runs while core sleeps");
	a_awake_all_on: assert property (awake |-> sysClkEn && freeClkEn && combPowerEn && !retainEn)
		else $error("clock or power off while awake");
	a_sys_periph_off: assert property (!sysClkEn |-> !periphClkEn)
		else $error("peripheral clock on without bus clock");
	a_hib_power: assert property (!freeClkEn |-> retainEn && !combPowerEn && !sysClkEn)
		else $error("hibernate power state wrong");
	a_irq_clk_kept: assert property (!sysClkEn && !retainEn |-> freeClkEn)
		else $error("interrupt clock stopped in mode two");
	a_sleep_needed: assert property (awake && !sleepReq |=> awake)
		else $error("low power entered without sleep");
	a_debug_block: assert property (awake && debugHold |=> awake)
		else $error("low power entered under debug hold");
	a_wake_return: assert property (!awake && freeClkEn && wakeIrq && !inHandler |=> awake)
		else $error("no return to active on wake");
	a_hib_hold: assert property (!freeClkEn && !wakeHib |=> !awake)
		else $error("hibernate left by other source");
endmodule : pmc_checker
`default_nettype wire

// ---- test/power_mode_controller_tb.sv ----
// Testbench driving the core side over APB and watching both ends.
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller_tb;
	import pmc_pkg::*;
	logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, lastErr;
	logic wakeIrq, wakeHigherPrio, wakeHib, porRst;
	logic [31:0] paddr, pwdata, prdata, rdv;
	logic [7:0] periphGateOff, periphClkEn;
	int miscompares = 0;
	int tests_run = 0;
	pmc_if pif();
	pmc_core_side u_pmc_core_side(.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wakeIrq(wakeIrq),
		.wakeHigherPrio(wakeHigherPrio), .wakeHib(wakeHib), .porRst(porRst), .bus(pif));
	pmc_power_mode_controller u_pmc_power_mode_controller(.clk(clk), .sys_rst(sys_rst), .bus(pif),
		.periphGateOff(periphGateOff), .periphClkEn(periphClkEn));
	pmc_checker u_pmc_checker(.clk(clk), .sys_rst(sys_rst), .sleepReq(pif.sleepReq), .inHandler(pif.inHandler),
		.debugHold(pif.debugHold), .wakeIrq(pif.wakeIrq), .wakeHib(pif.wakeHib), .coreClkEn(pif.coreClkEn),
		.sysClkEn(pif.sysClkEn), .periphClkEn(pif.periphClkEn), .freeClkEn(pif.freeClkEn),
		.combPowerEn(pif.combPowerEn), .retainEn(pif.retainEn), .awake(pif.awake));
	// ****************************************
	// Bus tasks and checks
	// ****************************************
	always #4 clk = ~clk;
	task automatic report_and_stop();
		if (miscompares == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {20'h40002, a};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdv = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic iw(input logic sel, input logic [15:0] v);
		apb(1'b1, PMC_WDATA_ADDR, {16'h0000, v});
		apb(1'b1, PMC_CMD_ADDR, {27'h0, sel, 4'h1});
	endtask : iw
	task automatic ir(input logic sel);
		apb(1'b1, PMC_CMD_ADDR, {27'h0, sel, 4'h2});
		do begin
			apb(1'b0, PMC_STAT_ADDR, 32'h0);
		end while (rdv[0] !== 1'b0);
		apb(1'b0, PMC_RDATA_ADDR, 32'h0);
	endtask : ir
	task automatic setm(input int m);
		iw(1'b1, PMC_KEY_FIRST);
		iw(1'b1, PMC_KEY_SECOND);
		iw(1'b0, 16'(m));
	endtask : setm
	task automatic pulse(input logic [2:0] v);
		{wakeHib, wakeHigherPrio, wakeIrq} <= v;
		repeat (2) @(posedge clk);
		{wakeHib, wakeHigherPrio, wakeIrq} <= 3'h0;
		repeat (2) @(posedge clk);
	endtask : pulse
	function automatic logic [4:0] gates();
		return {pif.coreClkEn, pif.sysClkEn, pif.freeClkEn, pif.retainEn, pif.awake};
	endfunction : gates
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{clk, psel, penable, pwrite, wakeIrq, wakeHigherPrio, wakeHib, porRst} = 8'h01;
		{paddr, pwdata} = 64'h0;
		sys_rst = 1'b1;
		periphGateOff = 8'h05;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		porRst <= 1'b0;
		ir(1'b0);
		chk("mode", rdv, 32'h0);
		ir(1'b1);
		chk("key", rdv, 32'h0);
		chk("gates", gates(), 5'h1d);
		chk("periph", periphClkEn, 8'hfa);
		iw(1'b0, 16'h0002);
		ir(1'b0);
		chk("mode", rdv, 32'h0);
		iw(1'b1, PMC_KEY_FIRST);
		iw(1'b1, PMC_KEY_SECOND);
		iw(1'b1, 16'h1234);
		iw(1'b0, 16'h0001);
		ir(1'b0);
		chk("mode", rdv, 32'h0);
		iw(1'b1, PMC_KEY_SECOND);
		iw(1'b1, PMC_KEY_FIRST);
		iw(1'b0, 16'h0003);
		ir(1'b0);
		chk("mode", rdv, 32'h0);
		for (int m = 0; m < 4; m++) begin
			setm(m);
			ir(1'b0);
			chk("mode", rdv, 32'(m));
			apb(1'b1, PMC_CORE_ADDR, (m == 3) ? 32'h5 : 32'h1);
			repeat (2) @(posedge clk);
			chk("gates", gates(), {1'b0, m < 2, m != 3, m == 3, m == 0});
			chk("periph", periphClkEn, (m < 2) ? 8'hfa : 8'h00);
			apb(1'b1, PMC_CORE_ADDR, 32'h0);
			pulse((m == 3) ? 3'h1 : 3'h0);
			chk("asleep", pif.awake, m == 0);
			pulse((m == 3) ? 3'h4 : 3'h1);
			chk("gates", gates(), 5'h1d);
			ir(1'b0);
			chk("mode", rdv, 32'(m));
		end
		setm(2);
		apb(1'b1, PMC_CORE_ADDR, 32'h9);
		repeat (2) @(posedge clk);
		chk("gates", gates(), 5'h0d);
		apb(1'b1, PMC_CORE_ADDR, 32'h0);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		setm(2);
		apb(1'b1, PMC_CORE_ADDR, 32'h1);
		repeat (2) @(posedge clk);
		chk("gates", gates(), 5'h0d);
		porRst <= 1'b1;
		@(posedge clk);
		porRst <= 1'b0;
		repeat (2) @(posedge clk);
		chk("gates", gates(), 5'h04);
		apb(1'b1, PMC_CORE_ADDR, 32'h0);
		pulse(3'h1);
		chk("asleep", pif.awake, 1'b1);
		setm(1);
		apb(1'b1, PMC_CORE_ADDR, 32'h3);
		apb(1'b1, PMC_CORE_ADDR, 32'h2);
		pulse(3'h1);
		chk("asleep", pif.awake, 1'b0);
		pulse(3'h2);
		chk("asleep", pif.awake, 1'b1);
		apb(1'b1, PMC_CORE_ADDR, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		chk("err", lastErr, 1'b1);
		chk("rdata", rdv, 32'h0);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		ir(1'b0);
		chk("mode", rdv, 32'h0);
		report_and_stop();
	end
	initial begin
		#400000;
		miscompares++;
		report_and_stop();
	end
endmodule : power_mode_controller_tb
`default_nettype wire
